// ==== rtl/pcgd_pkg.sv ====
// Package for peripheral clock gate and disable block
package pcgd_pkg;

  // Register word offsets (byte addresses)
  localparam logic [7:0] OFF_ANALOG  = 8'h00;
  localparam logic [7:0] OFF_COMPAR  = 8'h04;
  localparam logic [7:0] OFF_CAPCMP  = 8'h08;
  localparam logic [7:0] OFF_TIMERS  = 8'h0c;
  localparam logic [7:0] OFF_SERIAL  = 8'h10;
  localparam logic [7:0] OFF_MISC    = 8'h14;
  localparam int         NUM_REGS    = 6;

  // Implemented-bit masks per register
  localparam logic [31:0] MASK_ANALOG = 32'h0000_1101;
  localparam logic [31:0] MASK_COMPAR = 32'h0000_0003;
  localparam logic [31:0] MASK_CAPCMP = 32'h001f_001f;
  localparam logic [31:0] MASK_TIMERS = 32'h0000_001f;
  localparam logic [31:0] MASK_SERIAL = 32'h0103_031f;
  localparam logic [31:0] MASK_MISC   = 32'h0001_0003;
  localparam logic [31:0] RESET_VAL   = 32'h0000_0000;

  // Field positions
  localparam int BIT_CONVERTER  = 0;
  localparam int BIT_CHARGE_TMR = 8;
  localparam int BIT_CMP_REF    = 12;
  localparam int BIT_CMP_ONE    = 0;
  localparam int BIT_CAPTURE    = 0;
  localparam int BIT_COMPARE    = 16;
  localparam int BIT_TIMER      = 0;
  localparam int BIT_UART       = 0;
  localparam int BIT_SPI        = 8;
  localparam int BIT_I2C        = 16;
  localparam int BIT_USB        = 24;
  localparam int BIT_CALENDAR   = 0;
  localparam int BIT_REF_OUT    = 1;
  localparam int BIT_PAR_PORT   = 16;

  // Per-peripheral off signals, one group each
  typedef struct packed {
    logic       converter_off;
    logic       charge_timer_off;
    logic       comparator_reference_off;
    logic [1:0] comparator_off;
    logic [4:0] capture_off;
    logic [4:0] compare_off;
    logic [4:0] timer_off;
    logic [4:0] uart_off;
    logic [1:0] spi_off;
    logic [1:0] i2c_off;
    logic       usb_off;
    logic       calendar_clock_off;
    logic       ref_clock_out_off;
    logic       parallel_port_off;
  } pcgd_off_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pcgd_apb_req_t;

endpackage

// ==== rtl/pcgd_top.sv ====
// Peripheral clock gate and disable register block with APB slave
`timescale 1ns/10ps

module pcgd_top #(
  parameter logic [31:0] PRESENT_ANALOG = 32'hffff_ffff,
  parameter logic [31:0] PRESENT_COMPAR = 32'hffff_ffff,
  parameter logic [31:0] PRESENT_CAPCMP = 32'hffff_ffff,
  parameter logic [31:0] PRESENT_TIMERS = 32'hffff_ffff,
  parameter logic [31:0] PRESENT_SERIAL = 32'hffff_ffff,
  parameter logic [31:0] PRESENT_MISC   = 32'hffff_ffff
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output pcgd_pkg::pcgd_off_t       clk_off,
  output pcgd_pkg::pcgd_off_t       reg_block
);

  // Whole block state
  typedef struct packed {
    logic [31:0]         analog;
    logic [31:0]         compar;
    logic [31:0]         capcmp;
    logic [31:0]         timers;
    logic [31:0]         serial;
    logic [31:0]         misc;
    logic                ready;
    logic [31:0]         rdata;
    logic                err;
    pcgd_pkg::pcgd_off_t off;
  } pcgd_state_t;

  pcgd_state_t st_ff;
  pcgd_state_t nxt_st;

  // Mask of w bits starting at bit p
  function automatic logic [31:0] bits_at(input int p, input int w);
    bits_at = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (i >= p && i < p + w) begin
        bits_at[i] = 1'b1;
      end
    end
  endfunction

  // Field layout per register, built from the field positions
  localparam logic [31:0] LAY_ANALOG =
    bits_at(pcgd_pkg::BIT_CONVERTER, 1) |
    bits_at(pcgd_pkg::BIT_CHARGE_TMR, 1) |
    bits_at(pcgd_pkg::BIT_CMP_REF, 1);
  localparam logic [31:0] LAY_COMPAR =
    bits_at(pcgd_pkg::BIT_CMP_ONE, 2);
  localparam logic [31:0] LAY_CAPCMP =
    bits_at(pcgd_pkg::BIT_CAPTURE, 5) |
    bits_at(pcgd_pkg::BIT_COMPARE, 5);
  localparam logic [31:0] LAY_TIMERS =
    bits_at(pcgd_pkg::BIT_TIMER, 5);
  localparam logic [31:0] LAY_SERIAL =
    bits_at(pcgd_pkg::BIT_UART, 5) |
    bits_at(pcgd_pkg::BIT_SPI, 2) |
    bits_at(pcgd_pkg::BIT_I2C, 2) |
    bits_at(pcgd_pkg::BIT_USB, 1);
  localparam logic [31:0] LAY_MISC =
    bits_at(pcgd_pkg::BIT_CALENDAR, 1) |
    bits_at(pcgd_pkg::BIT_REF_OUT, 1) |
    bits_at(pcgd_pkg::BIT_PAR_PORT, 1);

  // Writable bits: documented layout gated by variant complement
  localparam logic [31:0] WM_ANALOG =
    pcgd_pkg::MASK_ANALOG & LAY_ANALOG & PRESENT_ANALOG;
  localparam logic [31:0] WM_COMPAR =
    pcgd_pkg::MASK_COMPAR & LAY_COMPAR & PRESENT_COMPAR;
  localparam logic [31:0] WM_CAPCMP =
    pcgd_pkg::MASK_CAPCMP & LAY_CAPCMP & PRESENT_CAPCMP;
  localparam logic [31:0] WM_TIMERS =
    pcgd_pkg::MASK_TIMERS & LAY_TIMERS & PRESENT_TIMERS;
  localparam logic [31:0] WM_SERIAL =
    pcgd_pkg::MASK_SERIAL & LAY_SERIAL & PRESENT_SERIAL;
  localparam logic [31:0] WM_MISC   =
    pcgd_pkg::MASK_MISC & LAY_MISC & PRESENT_MISC;

  // Masked merge of write data into a register
  function automatic logic [31:0] upd(input logic [31:0] cur,
                                      input logic [31:0] wd,
                                      input logic [31:0] m);
    upd = (cur & ~m) | (wd & m);
  endfunction

  // Map register contents onto per-peripheral off bits
  function automatic pcgd_pkg::pcgd_off_t map_off(
    input logic [31:0] a, input logic [31:0] c, input logic [31:0] p,
    input logic [31:0] t, input logic [31:0] s, input logic [31:0] m);
    map_off.converter_off            = a[pcgd_pkg::BIT_CONVERTER];
    map_off.charge_timer_off         = a[pcgd_pkg::BIT_CHARGE_TMR];
    map_off.comparator_reference_off = a[pcgd_pkg::BIT_CMP_REF];
    map_off.comparator_off = c[pcgd_pkg::BIT_CMP_ONE +: 2];
    map_off.capture_off    = p[pcgd_pkg::BIT_CAPTURE +: 5];
    map_off.compare_off    = p[pcgd_pkg::BIT_COMPARE +: 5];
    map_off.timer_off      = t[pcgd_pkg::BIT_TIMER +: 5];
    map_off.uart_off       = s[pcgd_pkg::BIT_UART +: 5];
    map_off.spi_off        = s[pcgd_pkg::BIT_SPI +: 2];
    map_off.i2c_off        = s[pcgd_pkg::BIT_I2C +: 2];
    map_off.usb_off        = s[pcgd_pkg::BIT_USB];
    map_off.calendar_clock_off = m[pcgd_pkg::BIT_CALENDAR];
    map_off.ref_clock_out_off  = m[pcgd_pkg::BIT_REF_OUT];
    map_off.parallel_port_off  = m[pcgd_pkg::BIT_PAR_PORT];
  endfunction

  // One-hot select of the register at a byte address
  function automatic logic [5:0] sel_of(input logic [7:0] a);
    sel_of = 6'h00;
    unique case (a)
      pcgd_pkg::OFF_ANALOG: sel_of = 6'h01;
      pcgd_pkg::OFF_COMPAR: sel_of = 6'h02;
      pcgd_pkg::OFF_CAPCMP: sel_of = 6'h04;
      pcgd_pkg::OFF_TIMERS: sel_of = 6'h08;
      pcgd_pkg::OFF_SERIAL: sel_of = 6'h10;
      pcgd_pkg::OFF_MISC:   sel_of = 6'h20;
      default:              sel_of = 6'h00;
    endcase
  endfunction

  // Read word for a one-hot select; no select reads zero
  function automatic logic [31:0] rd_of(input logic [5:0]  s,
                                        input pcgd_state_t q);
    rd_of = pcgd_pkg::RESET_VAL;
    unique case (1'b1)
      s[0]:    rd_of = q.analog;
      s[1]:    rd_of = q.compar;
      s[2]:    rd_of = q.capcmp;
      s[3]:    rd_of = q.timers;
      s[4]:    rd_of = q.serial;
      s[5]:    rd_of = q.misc;
      default: rd_of = pcgd_pkg::RESET_VAL;
    endcase
  endfunction

  // Masked update of one register under its own strobe
  function automatic logic [31:0] wr_of(input logic        en,
                                        input logic [31:0] cur,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    wr_of = cur;
    if (en) begin
      wr_of = upd(cur, wd, m);
    end
  endfunction

  logic        setup;    // Setup phase of a transfer
  logic        access;   // Access phase of a transfer
  logic        wr;       // Write strobe, setup phase
  logic        mapped;   // Address names a register
  logic [5:0]  sel;      // One-hot register select
  logic [5:0]  wen;      // Per-register write strobes
  logic [31:0] rd_word;  // Word picked by the read mux

  // Next state: APB decode, register update, read mux
  always_comb begin
    // Defaults: hold state, no answer
    nxt_st       = st_ff;
    nxt_st.ready = 1'b0;
    nxt_st.err   = 1'b0;

    // Bus phase decode
    setup  = psel && !penable;
    access = psel && penable;
    wr     = setup && pwrite;

    // Address decode and per-register strobes
    sel    = sel_of(paddr);
    mapped = |sel;
    wen    = wr ? sel : 6'h00;

    // Analog register: converter, charge timer, reference
    nxt_st.analog = wr_of(wen[0], st_ff.analog, pwdata, WM_ANALOG);

    // Comparator register
    nxt_st.compar = wr_of(wen[1], st_ff.compar, pwdata, WM_COMPAR);

    // Capture and compare register
    nxt_st.capcmp = wr_of(wen[2], st_ff.capcmp, pwdata, WM_CAPCMP);

    // Timer register
    nxt_st.timers = wr_of(wen[3], st_ff.timers, pwdata, WM_TIMERS);

    // Serial register: uart, spi, i2c, usb
    nxt_st.serial = wr_of(wen[4], st_ff.serial, pwdata, WM_SERIAL);

    // Misc register: calendar, reference out, parallel port
    nxt_st.misc = wr_of(wen[5], st_ff.misc, pwdata, WM_MISC);

    // Read data captured at setup, held otherwise
    rd_word = rd_of(sel, st_ff);
    if (setup) begin
      nxt_st.rdata = rd_word;
      nxt_st.ready = 1'b1;
      nxt_st.err   = !mapped;
    end
    // Zero-wait-state answer; ready drops after access
    if (access && st_ff.ready) begin
      nxt_st.ready = 1'b0;
    end
    // Clock stop and register block per peripheral
    nxt_st.off = map_off(nxt_st.analog, nxt_st.compar, nxt_st.capcmp,
                         nxt_st.timers, nxt_st.serial, nxt_st.misc);
  end

  // State register, all disables clear at reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign pready    = st_ff.ready;
  assign prdata    = st_ff.rdata;
  assign pslverr   = st_ff.err;
  assign clk_off   = st_ff.off;
  assign reg_block = st_ff.off;

endmodule

// ==== sim/pcgd_periph_model.sv ====
// Far-side peripheral with gated clock and own register
`timescale 1ns/10ps
module pcgd_periph_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       gate_off,
  input  wire logic       blocked,
  input  wire logic       wr,
  input  wire logic [7:0] wd,
  output logic      [7:0] ctrl_ff,
  output logic      [7:0] ticks_ff
);
  // Ticks on a live clock, drops writes while blocked
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= 8'h00;
      ticks_ff <= 8'h00;
    end else begin
      if (!gate_off) ticks_ff <= ticks_ff + 8'h01;
      if (wr && !blocked) ctrl_ff <= wd;
    end
  end
endmodule

// ==== sim/pcgd_checker.sv ====
// Assertion checker for peripheral disable block
`timescale 1ns/10ps
module pcgd_checker #(
  parameter logic [31:0] PRESENT_TIMERS = 32'hffff_ffff
) (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire pcgd_pkg::pcgd_off_t clk_off,
  input wire pcgd_pkg::pcgd_off_t reg_block
);
  // One clock domain, reset disables
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Setup phase of a write to one offset
  sequence s_wr(logic [7:0] a);
    psel && !penable && pwrite && paddr == a;
  endsequence
  // Write data of the previous edge, short alias of clk_off
  logic [31:0]         w_q;
  pcgd_pkg::pcgd_off_t c;
  always_ff @(posedge ref_clk) w_q <= pwdata;
  assign c = clk_off;
  chk_analog_bits: assert property (s_wr(8'h00) |=>
    {c.converter_off, c.charge_timer_off, c.comparator_reference_off}
    == {w_q[0], w_q[8], w_q[12]}) else $error("analog bits");
  chk_compar_bits: assert property (s_wr(8'h04) |=>
    c.comparator_off == w_q[1:0]) else $error("comparator bits");
  chk_capcmp_bits: assert property (s_wr(8'h08) |=>
    c.capture_off == w_q[4:0] && c.compare_off == w_q[20:16])
    else $error("capture bits");
  chk_timer_bits: assert property (s_wr(8'h0c) |=>
    c.timer_off == (w_q[4:0] & PRESENT_TIMERS[4:0])) else $error("timers");
  chk_serial_bits: assert property (s_wr(8'h10) |=>
    {c.uart_off, c.spi_off, c.i2c_off, c.usb_off}
    == {w_q[4:0], w_q[9:8], w_q[17:16], w_q[24]}) else $error("serial");
  chk_misc_bits: assert property (s_wr(8'h14) |=>
    {c.calendar_clock_off, c.ref_clock_out_off, c.parallel_port_off}
    == {w_q[0], w_q[1], w_q[16]}) else $error("misc bits");
  chk_block_follows: assert property (reg_block == clk_off)
    else $error("block differs");
  chk_unmapped_err: assert property (psel && !penable && paddr > 8'h14
    |=> pready && pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped");
endmodule

bind pcgd_top pcgd_checker #(.PRESENT_TIMERS(PRESENT_TIMERS)) u_chk (
  .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .clk_off, .reg_block);

// ==== sim/pcgd_bench.sv ====
// Self-checking bench for peripheral disable block
`timescale 1ns/10ps
module pcgd_bench;
  typedef struct packed {logic [7:0] a; logic [31:0] w, r; logic e;} pcgd_row_t;
  logic                ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0;
  logic                penable = 1'b0, pwrite = 1'b0, pm_wr = 1'b0;
  logic                pready, pslverr, err;
  logic [7:0]          paddr = 8'h00, pm_wd = 8'h00, pm_ctrl, pm_ticks, t0;
  logic [31:0]         pwdata = 32'h0000_0000, prdata, rd;
  pcgd_pkg::pcgd_off_t clk_off, reg_block;
  int                  failures = 0, n_checks = 0;
  pcgd_row_t           rows [8] = '{
    '{8'h00, 32'hffff_ffff, 32'h0000_1101, 1'b0},
    '{8'h04, 32'hffff_ffff, 32'h0000_0003, 1'b0},
    '{8'h08, 32'hffff_ffff, 32'h001f_001f, 1'b0},
    '{8'h0c, 32'hffff_ffff, 32'h0000_000f, 1'b0},
    '{8'h10, 32'hffff_ffff, 32'h0103_031f, 1'b0},
    '{8'h14, 32'hffff_ffff, 32'h0001_0003, 1'b0},
    '{8'h18, 32'hffff_ffff, 32'h0000_0000, 1'b1},
    '{8'h00, 32'h0000_0100, 32'h0000_0100, 1'b0}};
  // Clock, 25 ns period
  always #12.5 ref_clk = ~ref_clk;
  // Variant without timer five
  pcgd_top #(.PRESENT_TIMERS(32'h0000_000f)) dut (.ref_clk, .sys_rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .clk_off, .reg_block);
  // Far side of the USB gate
  pcgd_periph_model pm (.ref_clk, .sys_rst, .gate_off(clk_off.usb_off),
    .blocked(reg_block.usb_off), .wr(pm_wr), .wd(pm_wd), .ctrl_ff(pm_ctrl),
    .ticks_ff(pm_ticks));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One APB transfer after an idle edge, bounded wait
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge ref_clk);
    if (k == 20) begin
      failures++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One write into the far-side register
  task automatic pm_write(input logic [7:0] d);
    @(posedge ref_clk);
    pm_wr <= 1'b1;
    pm_wd <= d;
    @(posedge ref_clk);
    pm_wr <= 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      check(rd, 32'h0000_0000);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      check(rd, rows[i].r);
      check(32'(err), 32'(rows[i].e));
    end
    apb(1'b1, 8'h10, 32'h0000_0000);
    pm_write(8'h01);
    t0 = pm_ticks;
    repeat (3) @(posedge ref_clk);
    check(32'(pm_ticks), 32'(t0 + 8'h03));
    pm_write(8'h00);
    apb(1'b1, 8'h10, 32'h0100_0000);
    check(32'(clk_off.usb_off & reg_block.usb_off), 32'h0000_0001);
    t0 = pm_ticks;
    pm_write(8'h5a);
    check(32'(pm_ticks), 32'(t0));
    check(32'(pm_ctrl), 32'h0000_0000);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
